//--- cbsf_map.svh
// Register offsets, field positions and reset values for cbsf
`ifndef CBSF_MAP_SVH
`define CBSF_MAP_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CBSF_OFF_CONTROL   8'h00
`define CBSF_OFF_COMMAND   8'h04
`define CBSF_OFF_STATUS    8'h08
`define CBSF_OFF_IRQ       8'h0c
`define CBSF_OFF_SLEEPSTAT 8'h10
`define CBSF_OFF_TXBUF     8'h14
`define CBSF_OFF_RXBUF     8'h18
`define CBSF_OFF_ACC_CODE  8'h24
`define CBSF_OFF_ACC_MASK  8'h28
// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define CBSF_CTL_RESET_REQ 0
`define CBSF_CTL_RIE       1
`define CBSF_CTL_SLEEP     2
`define CBSF_CTL_RXA_SEL   3
`define CBSF_CTL_RXB_SEL   4
`define CBSF_CTL_WAKE_COMPARATOR_SELECT   5
`define CBSF_CTL_RESET_VAL 6'h01
// ------------------------------------------------------------
// Command register bits (write one, self clearing)
// ------------------------------------------------------------
`define CBSF_CMD_TX_REQ    0
`define CBSF_CMD_ABORT     1
`define CBSF_CMD_RELEASE   2
`define CBSF_CMD_CLR_OVR   3
// ------------------------------------------------------------
// Status register bits
// ------------------------------------------------------------
`define CBSF_ST_RBS        0
`define CBSF_ST_OVERRUN    1
`define CBSF_ST_TBA        2
`define CBSF_ST_TCS        3
`define CBSF_ST_RX_BUSY    4
`define CBSF_ST_TX_BUSY    5
`define CBSF_ST_ASLEEP     6
// ------------------------------------------------------------
// Interrupt flag register bits (cleared by read)
// ------------------------------------------------------------
`define CBSF_IRQ_RIF       0
`define CBSF_IRQ_WAKE      1
// ------------------------------------------------------------
// Message word layout and bus answers
// ------------------------------------------------------------
`define CBSF_ID_MSB        10
`define CBSF_ID_FILT_LSB   3
`define CBSF_RESP_OKAY     2'b00
`define CBSF_RESP_SLVERR   2'b10
`endif

//--- cbsf_pkg.sv
// Shared types for the cbsf bus controller block
package cbsf_pkg;
    typedef enum logic [1:0] {
        CBSF_AWAKE  = 2'b01,
        CBSF_ASLEEP = 2'b10
    } cbsf_sleep_t;
endpackage

//--- cbsf_top.sv
// Bus controller: sleep, transmit lock, two-deep receive, filter
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "cbsf_map.svh"
module cbsf_top #(
    parameter int MSG_W = 32
) (
    input  wire logic             aclk,          // Module clock
    input  wire logic             aresetn,       // Sync reset, low
    input  wire logic [7:0]       s_awaddr,      // Write address
    input  wire logic             s_awvalid,     // Write addr valid
    output logic                  s_awready,     // Write addr ready
    input  wire logic [31:0]      s_wdata,       // Write data
    input  wire logic [3:0]       s_wstrb,       // Byte strobes
    input  wire logic             s_wvalid,      // Write data valid
    output logic                  s_wready,      // Write data ready
    output logic [1:0]            s_bresp,       // Write response
    output logic                  s_bvalid,      // Response valid
    input  wire logic             s_bready,      // Response ready
    input  wire logic [7:0]       s_araddr,      // Read address
    input  wire logic             s_arvalid,     // Read addr valid
    output logic                  s_arready,     // Read addr ready
    output logic [31:0]           s_rdata,       // Read data
    output logic [1:0]            s_rresp,       // Read response
    output logic                  s_rvalid,      // Read data valid
    input  wire logic             s_rready,      // Read data ready
    input  wire logic             rx_pin_a,      // Bus receive pin A
    input  wire logic             rx_pin_b,      // Bus receive pin B
    output logic                  rx_a_connected,// Pin A to comparator
    output logic                  rx_b_connected,// Pin B to comparator
    output logic                  rx_level,      // Resolved bus level
    output logic                  wake_detect,   // Sleep comparator out
    input  wire logic             rx_busy,       // Engine receiving
    input  wire logic             tx_busy,       // Engine transmitting
    input  wire logic             rx_frame_valid,// Frame done pulse
    input  wire logic [MSG_W-1:0] rx_frame,      // Received frame word
    input  wire logic             tx_started,    // Engine began frame
    input  wire logic             tx_done,       // Frame sent ok pulse
    output logic                  tx_request,    // Frame awaits send
    output logic                  tx_abort,      // Abort pending frame
    output logic [MSG_W-1:0]      tx_frame,      // Frame to send
    output logic                  asleep,        // Controller asleep
    output logic                  irq            // Receive or wake flag pending
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic accept(input logic [MSG_W-1:0] msg,
                                    input logic [7:0] code,
                                    input logic [7:0] mask);
        logic [7:0] idt;
        idt = msg[`CBSF_ID_MSB:`CBSF_ID_FILT_LSB];
        return ((idt ^ code) & ~mask) == 8'h00;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and comparator
    // ------------------------------------------------------------
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic       pin_a;
    logic       pin_b;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 2'h3;
            sync_b <= 2'h3;
        end else begin
            sync_a <= {sync_a[0], rx_pin_a};
            sync_b <= {sync_b[0], rx_pin_b};
        end
    end
    assign pin_a = sync_a[1];
    assign pin_b = sync_b[1];

    logic [5:0] control;
    logic       reset_req;
    logic       receive_interrupt_enable;
    logic       sleep_bit;
    logic       sel_a;
    logic       sel_b;
    logic       wake_comparator_select;
    logic       use_a;
    logic       use_b;
    logic       level;
    logic       dominant;
    assign reset_req = control[`CBSF_CTL_RESET_REQ];
    assign receive_interrupt_enable       = control[`CBSF_CTL_RIE];
    assign sleep_bit = control[`CBSF_CTL_SLEEP];
    assign sel_a     = control[`CBSF_CTL_RXA_SEL];
    assign sel_b     = control[`CBSF_CTL_RXB_SEL];
    assign wake_comparator_select   = control[`CBSF_CTL_WAKE_COMPARATOR_SELECT];
    // Both or neither selected keeps both pins connected
    assign use_a = !(sel_a && !sel_b);
    assign use_b = !(sel_b && !sel_a);
    // Disconnected pin reads as recessive reference
    assign level = (use_a ? pin_a : 1'b1) & (use_b ? pin_b : 1'b1);
    // Digital stand-in for the analog comparator
    assign dominant = wake_comparator_select ? ((use_a && !pin_a) || (use_b && !pin_b))
                              : (pin_a != pin_b);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_a_connected <= 1'b1;
            rx_b_connected <= 1'b1;
            rx_level       <= 1'b1;
            wake_detect    <= 1'b0;
        end else begin
            rx_a_connected <= use_a;
            rx_b_connected <= use_b;
            rx_level       <= level;
            wake_detect    <= dominant;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        wr_mapped;
    logic        wr_ctl;
    logic        wr_cmd;
    logic        wr_tx;
    logic        wr_code;
    logic        wr_mask;
    logic [3:0]  cmd;
    assign wr_go = aw_held && w_held && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `CBSF_RESP_OKAY;
        end else begin
            s_awready <= !aw_held && !(s_awvalid && s_awready);
            s_wready  <= !w_held && !(s_wvalid && s_wready);
            if (s_awvalid && s_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (wr_go) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= wr_mapped ? `CBSF_RESP_OKAY
                                      : `CBSF_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_ctl  = wr_go && aw_addr == `CBSF_OFF_CONTROL;
        wr_cmd  = wr_go && aw_addr == `CBSF_OFF_COMMAND;
        wr_tx   = wr_go && aw_addr == `CBSF_OFF_TXBUF;
        wr_code = wr_go && aw_addr == `CBSF_OFF_ACC_CODE;
        wr_mask = wr_go && aw_addr == `CBSF_OFF_ACC_MASK;
        wr_mapped = wr_ctl || wr_cmd || wr_tx || wr_code || wr_mask
                 || aw_addr == `CBSF_OFF_STATUS
                 || aw_addr == `CBSF_OFF_IRQ
                 || aw_addr == `CBSF_OFF_SLEEPSTAT
                 || aw_addr == `CBSF_OFF_RXBUF;
        cmd = (wr_cmd && w_strb[0]) ? w_data[3:0] : 4'h0;
    end

    // ------------------------------------------------------------
    // Control, acceptance code and mask
    // ------------------------------------------------------------
    logic [7:0] acc_code;
    logic [7:0] acc_mask;
    logic       hw_wake_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= `CBSF_CTL_RESET_VAL;
        end else if (wr_ctl && w_strb[0]) begin
            control <= w_data[5:0];
        end else if (hw_wake_clear) begin
            control[`CBSF_CTL_SLEEP] <= 1'b0;
        end
    end

    // Left unreset on purpose: software loads it under reset request
    always_ff @(posedge aclk) begin
        if (wr_code && w_strb[0] && reset_req) begin
            acc_code <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_mask <= 8'hff;
        end else if (wr_mask && w_strb[0] && reset_req) begin
            acc_mask <= w_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // Transmit buffer and completion
    // ------------------------------------------------------------
    logic transmit_buffer_access_flag;
    logic transmit_complete_flag;
    logic tx_running;
    logic tx_rx_overrun;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_frame <= '0;
        end else if (wr_tx && transmit_buffer_access_flag) begin
            tx_frame <= merge(tx_frame, w_data, w_strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            transmit_buffer_access_flag        <= 1'b1;
            transmit_complete_flag        <= 1'b0;
            tx_request <= 1'b0;
            tx_abort   <= 1'b0;
            tx_running <= 1'b0;
        end else begin
            tx_abort <= 1'b0;
            if (cmd[`CBSF_CMD_TX_REQ] && transmit_buffer_access_flag) begin
                transmit_buffer_access_flag        <= 1'b0;
                transmit_complete_flag        <= 1'b0;
                tx_request <= 1'b1;
            end else if (cmd[`CBSF_CMD_ABORT] && tx_request
                         && !tx_running) begin
                transmit_buffer_access_flag        <= 1'b1;
                tx_request <= 1'b0;
                tx_abort   <= 1'b1;
            end
            if (tx_started && tx_request) begin
                tx_running <= 1'b1;
            end
            if (tx_done && tx_running) begin
                tx_running <= 1'b0;
                tx_request <= 1'b0;
                transmit_buffer_access_flag        <= 1'b1;
                transmit_complete_flag        <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Two receive buffers, slot 0 faces software
    // ------------------------------------------------------------
    logic [MSG_W-1:0] rx_buf [2];
    logic [1:0]       rx_count;
    logic             overrun;
    logic             receive_interrupt_flag;
    logic             got;
    logic             release_now;
    logic [1:0]       base;
    logic             store;
    logic             rd_irq;

    assign got = rx_frame_valid && !reset_req
                 && accept(rx_frame, acc_code, acc_mask);
    assign release_now = cmd[`CBSF_CMD_RELEASE] && rx_count != 2'd0;
    assign base  = release_now ? rx_count - 2'd1 : rx_count;
    assign store = got && base != 2'd2;
    // Own frame start needs a free receive slot; none free means overrun
    assign tx_rx_overrun = tx_started && tx_request
                           && base == 2'd2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf[0] <= '0;
            rx_buf[1] <= '0;
        end else begin
            if (release_now && rx_count == 2'd2) begin
                rx_buf[0] <= rx_buf[1];
            end
            if (rx_frame_valid && base != 2'd2) begin
                // Rejected frames land here too and get overwritten
                rx_buf[base[0]] <= rx_frame;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            rx_count <= 2'd0;
        end else begin
            rx_count <= base + {1'b0, store};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            overrun <= 1'b0;
        end else if ((got && base == 2'd2) || tx_rx_overrun) begin
            overrun <= 1'b1;
        end else if (cmd[`CBSF_CMD_CLR_OVR]) begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            receive_interrupt_flag <= 1'b0;
        end else if (store && receive_interrupt_enable) begin
            receive_interrupt_flag <= 1'b1;
        end else if (rd_irq) begin
            receive_interrupt_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    cbsf_pkg::cbsf_sleep_t sleep_state;
    logic sleep_prev;
    logic wake_flag;
    logic sleep_ok;
    logic sleep_rise;
    logic bus_active;
    logic pending;
    logic set_wake;

    assign sleep_rise = sleep_bit && !sleep_prev;
    assign bus_active = rx_busy || tx_busy || tx_running || !level;
    assign pending    = receive_interrupt_flag || wake_flag || overrun;
    assign hw_wake_clear = sleep_state == cbsf_pkg::CBSF_ASLEEP
                           && dominant;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_prev <= 1'b0;
        end else begin
            sleep_prev <= sleep_bit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_state <= cbsf_pkg::CBSF_AWAKE;
            sleep_ok    <= 1'b0;
            set_wake    <= 1'b0;
        end else begin
            set_wake <= 1'b0;
            unique case (sleep_state)
                cbsf_pkg::CBSF_AWAKE: begin
                    if (sleep_rise) begin
                        if (pending || bus_active) begin
                            set_wake <= 1'b1;
                            sleep_ok <= 1'b0;
                        end else begin
                            sleep_state <= cbsf_pkg::CBSF_ASLEEP;
                            sleep_ok    <= 1'b1;
                        end
                    end
                end
                cbsf_pkg::CBSF_ASLEEP: begin
                    if (dominant) begin
                        sleep_state <= cbsf_pkg::CBSF_AWAKE;
                        set_wake    <= 1'b1;
                    end else if (!sleep_bit) begin
                        sleep_state <= cbsf_pkg::CBSF_AWAKE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            wake_flag <= 1'b0;
        end else if (set_wake) begin
            wake_flag <= 1'b1;
        end else if (rd_irq) begin
            wake_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            asleep <= 1'b0;
            irq    <= 1'b0;
        end else begin
            asleep <= sleep_state == cbsf_pkg::CBSF_ASLEEP;
            irq    <= receive_interrupt_flag || wake_flag;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        rd_go;
    assign rd_go  = s_arvalid && s_arready;
    assign rd_irq = rd_go && s_araddr == `CBSF_OFF_IRQ;

    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        unique case (s_araddr)
            `CBSF_OFF_CONTROL:   rd_val[5:0] = control;
            `CBSF_OFF_COMMAND:   rd_val = 32'h0;
            `CBSF_OFF_STATUS: begin
                rd_val[`CBSF_ST_RBS]     = rx_count != 2'd0;
                rd_val[`CBSF_ST_OVERRUN] = overrun;
                rd_val[`CBSF_ST_TBA]     = transmit_buffer_access_flag;
                rd_val[`CBSF_ST_TCS]     = transmit_complete_flag;
                rd_val[`CBSF_ST_RX_BUSY] = rx_busy;
                rd_val[`CBSF_ST_TX_BUSY] = tx_running;
                rd_val[`CBSF_ST_ASLEEP]  = asleep;
            end
            `CBSF_OFF_IRQ: begin
                rd_val[`CBSF_IRQ_RIF]  = receive_interrupt_flag;
                rd_val[`CBSF_IRQ_WAKE] = wake_flag;
            end
            `CBSF_OFF_SLEEPSTAT: rd_val[0] = sleep_ok;
            `CBSF_OFF_TXBUF:     rd_val = transmit_buffer_access_flag ? tx_frame : 32'h0;
            `CBSF_OFF_RXBUF:     rd_val = rx_buf[0];
            `CBSF_OFF_ACC_CODE:
                rd_val[7:0] = reset_req ? acc_code : 8'h00;
            `CBSF_OFF_ACC_MASK:  rd_val[7:0] = acc_mask;
            default:             rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= `CBSF_RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !rd_go;
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_val;
                s_rresp  <= rd_ok ? `CBSF_RESP_OKAY
                                  : `CBSF_RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- cbsf_chk.sv
// Port assertions for cbsf_top
`timescale 1ns/1ps
module cbsf_chk (
    input wire logic aclk, aresetn, s_arvalid, s_arready, s_rvalid,
    input wire logic s_rready, rx_pin_a, rx_pin_b, rx_a_connected,
    input wire logic rx_b_connected, rx_level, wake_detect, asleep,
    input wire logic rx_busy, tx_busy, tx_request, tx_done, tx_abort
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Five cycles cover the pin synchroniser and the output register
    sequence low_a; (!rx_pin_a && rx_a_connected)[*5]; endsequence
    sequence split;
        (rx_a_connected && rx_b_connected && rx_pin_a != rx_pin_b)[*5];
    endsequence
    a_pin_cut: assert property (rx_a_connected | rx_b_connected)
        else $error("both pins cut");
    a_dom_wins: assert property (low_a |-> !rx_level)
        else $error("low pins read recessive");
    a_split_wake: assert property (split |-> wake_detect)
        else $error("no wake on split pins");
    a_bus_wake: assert property
        (asleep && wake_detect |-> ##[1:3] !asleep) else $error("no wake");
    a_abort_drop: assert property
        (tx_abort |-> ##[0:1] !tx_request) else $error("abort kept frame");
    a_done_free: assert property
        (tx_done && tx_request |=> !tx_request) else $error("frame kept");
    a_sleep_idle: assert property
        ($rose(asleep) |-> !rx_busy && !tx_busy) else $error("slept busy");
    a_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read not answered");
    a_rd_hold: assert property (s_rvalid && !s_rready |=> s_rvalid)
        else $error("read data dropped");
endmodule
bind cbsf_top cbsf_chk cbsf_chk_i (.aclk, .aresetn, .s_arvalid, .s_arready,
    .s_rvalid, .s_rready, .rx_pin_a, .rx_pin_b, .rx_a_connected, .asleep,
    .rx_b_connected, .rx_level, .wake_detect, .rx_busy, .tx_busy,
    .tx_request, .tx_done, .tx_abort);

//--- cbsf_node.sv
// Protocol engine and remote node model
`timescale 1ns/1ps
module cbsf_node (
    input  wire logic       aclk,          // Module clock
    input  wire logic       tx_request,    // Own frame pending
    input  wire logic       tx_abort,      // Pending frame dropped
    input  wire logic [7:0] dly,           // Start delay and frame time
    input  wire logic       rx_go,         // Remote node begins a frame
    output logic            tx_started,    // Own frame begins
    output logic            tx_done,       // Own frame sent
    output logic            tx_busy,       // Own frame on the bus
    output logic            rx_busy,       // Remote frame on the bus
    output logic            rx_frame_valid // Remote frame complete
);
    logic [7:0] cnt = 8'h00;
    logic [2:0] rcnt = 3'h0;
    initial {tx_started, tx_done, tx_busy, rx_busy, rx_frame_valid} = 5'h0;
    always @(posedge aclk) begin
        {tx_started, tx_done, rx_frame_valid} <= 3'h0;
        if (!tx_request || tx_abort) begin
            {cnt, tx_busy} <= 9'h0;
        end else if (cnt != dly) begin
            cnt <= cnt + 8'h01;
        end else begin
            {tx_started, tx_done, tx_busy, cnt} <= {~tx_busy, tx_busy,
                ~tx_busy, 8'h00};
        end
        rcnt <= rx_go ? 3'h4 : rcnt - {2'h0, rcnt != 3'h0};
        rx_frame_valid <= (rcnt == 3'h1);
        rx_busy <= rx_go || rcnt > 3'h1;
    end
endmodule

//--- testbench.sv
// Self-checking bench for cbsf_top
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, rx_pin_a = 1'b1, rx_pin_b = 1'b1;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, dly = 8'h02;
    logic [31:0] s_wdata = 32'h0, rx_frame = 32'h0, s_rdata, tx_frame, v;
    logic [3:0] s_wstrb = 4'hf;
    logic [1:0] s_bresp, s_rresp, e;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, rx_go = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, s_awready, s_wready, s_bvalid;
    logic s_arready, s_rvalid, rx_a_connected, rx_b_connected, rx_level;
    logic wake_detect, rx_busy, tx_busy, rx_frame_valid, tx_started, irq;
    logic tx_done, tx_request, tx_abort, asleep;
    int err_total = 0, cmp_count = 0, cycles = 0;
    cbsf_top cbsf_top_i (.*);
    cbsf_node cbsf_node_i (.*);
    always #10 aclk = ~aclk;
    task automatic results;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            err_total++;
            $display("wrong value at %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        @(posedge aclk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        s_rready <= 1'b0;
        {v, e} = {s_rdata, s_rresp};
        if (x !== 32'hffffffff) chk(v, x);
    endtask
    task automatic rx(input logic [31:0] f);
        @(posedge aclk);
        {rx_frame, rx_go} <= {f, 1'b1};
        @(posedge aclk);
        rx_go <= 1'b0;
        do @(posedge aclk); while (!rx_frame_valid);
    endtask
    task automatic t_regs;
        rc(8'h00, 32'h01);
        rc(8'h08, 32'h04);
        wr(8'h24, 32'ha5);
        wr(8'h28, 32'h0f);
        rc(8'h30, 32'h0);
        chk({30'h0, e}, 32'h2);
        wr(8'h30, 32'h0);
        chk({30'h0, s_bresp}, 32'h2);
        wr(8'h00, 32'h02);
        wr(8'h24, 32'h00);
        wr(8'h00, 32'h03);
        rc(8'h24, 32'ha5);
        wr(8'h00, 32'h02);
    endtask
    task automatic t_pins;
        rx_pin_a <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            wr(8'h00, 32'h02 | 32'(s << 3));
            @(posedge aclk);
            e = (s % 4 == 1) ? 2'b01 : (s % 4 == 2) ? 2'b10 : 2'b11;
            chk({30'h0, rx_a_connected, rx_b_connected}, {30'h0, e});
            chk({31'h0, rx_level}, {31'h0, ~e[1]});
            chk({31'h0, wake_detect}, {31'h0, s > 3 ? e[1] : 1'b1});
        end
        rx_pin_a <= 1'b1;
        wr(8'h00, 32'h02);
    endtask
    task automatic t_rx;
        rx(32'h44000298);
        rc(8'h08, 32'h04);
        rx(32'h11000518);
        rc(8'h08, 32'h05);
        chk({31'h0, irq}, 32'h1);
        rc(8'h0c, 32'h01);
        rc(8'h0c, 32'h00);
        chk({31'h0, irq}, 32'h0);
        rx(32'h22000519);
        rx(32'h3300051a);
        rc(8'h08, 32'h07);
        rc(8'h18, 32'h11000518);
        wr(8'h04, 32'h04);
        rc(8'h08, 32'h07);
        rc(8'h18, 32'h22000519);
        wr(8'h04, 32'h0c);
        rc(8'h08, 32'h04);
    endtask
    // Long start delay keeps the frame pending while the lock is probed
    task automatic t_tx;
        wr(8'h14, 32'h00c0ffee);
        dly <= 8'hc8;
        wr(8'h04, 32'h01);
        wr(8'h14, 32'h0badf00d);
        chk(tx_frame, 32'h00c0ffee);
        rc(8'h08, 32'h00);
        wr(8'h04, 32'h02);
        rc(8'h08, 32'h04);
        dly <= 8'h03;
        rx(32'h11000518);
        rx(32'h22000519);
        wr(8'h04, 32'h01);
        do @(posedge aclk); while (!tx_done);
        rc(8'h08, 32'h0f);
        wr(8'h04, 32'h04);
        wr(8'h04, 32'h0c);
    endtask
    task automatic t_sleep;
        rc(8'h0c, 32'hffffffff);
        wr(8'h00, 32'h06);
        rc(8'h10, 32'h01);
        rc(8'h08, 32'h4c);
        wr(8'h00, 32'h02);
        rc(8'h0c, 32'h00);
        chk({31'h0, asleep}, 32'h0);
        dly <= 8'h3c;
        wr(8'h04, 32'h01);
        do @(posedge aclk); while (!tx_started);
        wr(8'h00, 32'h06);
        rc(8'h0c, 32'h02);
        rc(8'h10, 32'h00);
        do @(posedge aclk); while (!tx_done);
        rc(8'h08, 32'h0c);
        wr(8'h00, 32'h02);
        wr(8'h00, 32'h06);
        do @(posedge aclk); while (!asleep);
        rx_pin_a <= 1'b0;
        do @(posedge aclk); while (asleep);
        rc(8'h00, 32'h02);
        rc(8'h0c, 32'h02);
        rx_pin_a <= 1'b1;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pins();
        t_rx();
        t_tx();
        t_sleep();
        results();
    end
endmodule
